// ===== common/pmr_pkg.sv
// Constants, register map and carrier types of the power mode and reset cause block.
// Assumes one 100 MHz clock and an AXI4-Lite master with 32-bit data.
package pmr_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_SEQ_NS    = 100;
	// Least time, rounded up to whole cycles
	localparam int RST_SEQ_CYC   = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 8;

	// ----------------------------------------------------------------
	// Register map: printed offsets are word indices
	// ----------------------------------------------------------------
	localparam int              ADDR_W                     = 12;
	localparam logic [7:0]      IDX_POWER_DOWN_COMMAND     = 8'hA4;
	localparam logic [7:0]      IDX_OPERATING_MODE_CONTROL = 8'hAE;
	localparam logic [7:0]      IDX_RESET_CAUSE            = 8'hB1;
	localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN_COMMAND  = {2'h0, IDX_POWER_DOWN_COMMAND, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_OPERATING_MODE_CONTROL =
		{2'h0, IDX_OPERATING_MODE_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE         = {2'h0, IDX_RESET_CAUSE, 2'h0};

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int         PD_WAKE_PIN_BIT  = 7;
	localparam int         PD_WAKE_TICK_BIT = 6;
	localparam int         PD_WAKE_COMP_BIT = 5;
	localparam int         OPM_POL_BIT      = 2;
	localparam int         OPM_LOCK_BIT     = 1;
	localparam int         OPM_WDT_BIT      = 0;
	localparam logic [2:0] OPM_RESET        = 3'h0;
	localparam logic [2:0] FLAGS_NONE       = 3'h0;
	localparam logic [2:0] CAUSE_INTERNAL   = 3'h0;
	localparam logic [2:0] CAUSE_PIN        = 3'h1;
	localparam logic [2:0] CAUSE_WDT        = 3'h2;
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_RUN          = 3'h0,
		MODE_DEEPEST      = 3'h1,
		MODE_MEMRET_OFF   = 3'h2,
		MODE_MEMRET_ON    = 3'h3,
		MODE_REGRET       = 3'h4,
		MODE_RSV5         = 3'h5,
		MODE_RSV6         = 3'h6,
		MODE_STANDBY      = 3'h7
	} pmr_mode_e;

	typedef enum logic [0:0] {
		PWR_RUN   = 1'h0,
		PWR_SLEEP = 1'h1
	} pmr_pwr_e;

	// ----------------------------------------------------------------
	// Bus carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} pmr_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pmr_axi_rsp_s;

	// Retention modes put the watchdog in reset when so enabled
	function automatic logic is_retention(input pmr_mode_e m);
		return (m == MODE_MEMRET_OFF) || (m == MODE_MEMRET_ON) || (m == MODE_REGRET);
	endfunction : is_retention

	// Nonzero, non-reserved command codes start a power-down
	function automatic logic is_sleep_cmd(input logic [2:0] c);
		return (c != MODE_RUN) && (c != MODE_RSV5) && (c != MODE_RSV6);
	endfunction : is_sleep_cmd

endpackage : pmr_pkg

// ===== rtl/pmr_top.sv
// Power mode control, wakeup cause flags and reset cause record, as an AXI4-Lite slave.
// Assumes wake pins and the reset pin are asynchronous; tick, comparator, watchdog
// and wake-pin enables come from logic on aclk.

// Overview of operation
// - Nonzero, non-reserved command write enters power-down; zero stays running
// - Codes select deep, retention, standby; 101/110 reserved
// - Command field reads back previous mode, 000 power-off
// - Bit 7 flags wakeup by pin
// - Bit 6 flags wakeup by timer tick
// - Bit 5 flags wakeup by comparator
// - Flags clear on read or power-down entry
// - Mode bit 2 makes pin subset active low
// - Mode bit 1 locks the retention latches
// - Mode bit 0 resets watchdog in retention modes
// - Generator, pin and watchdog resets share one sequence
// - Cause codes 000 generator, 001 pin, 010 watchdog
// - Any write to cause register clears it
// - Pin and watchdog causes accumulate until cleared
module pmr_top
	import pmr_pkg::*;
#(
	parameter int         NPIN     = 8,
	parameter logic [7:0] POL_MASK = 8'h44
) (
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// Register bus
	input  wire pmr_axi_req_s    axi_req,
	output      pmr_axi_rsp_s    axi_rsp,
	// Wakeup sources
	input  wire logic [NPIN-1:0] wake_pin,
	input  wire logic [NPIN-1:0] wake_pin_en,
	input  wire logic            tick_evt,
	input  wire logic            comp_evt,
	// Reset sources
	input  wire logic            reset_pin_n,
	input  wire logic            wdt_timeout,
	// System controls
	output logic                 sys_reset,
	output logic                 sleep_active,
	output pmr_mode_e            sleep_mode,
	output logic                 mcu_clk_stop,
	output logic                 wdt_hold_reset,
	output logic                 wdt_halt,
	output logic                 ret_latch_lock,
	output logic                 wake_pol_low
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pmr_axi_rsp_s      rsp;
		logic              aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_held;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		pmr_pwr_e          pwr;
		pmr_mode_e         cur_mode;
		pmr_mode_e         prev_mode;
		logic [2:0]        wake_flags;
		logic [2:0]        opm;
		logic [2:0]        cause;
		logic [CNT_W-1:0]  rst_cnt;
		logic [NPIN-1:0]   pin_s1;
		logic [NPIN-1:0]   pin_s2;
		logic              rpin_s1;
		logic              rpin_s2;
		logic              rpin_s3;
		logic              sys_reset;
		logic              sleep_active;
		pmr_mode_e         sleep_mode;
		logic              mcu_clk_stop;
		logic              wdt_hold;
		logic              wdt_halt;
		logic              latch_lock;
		logic              pol_low;
	} pmr_state_s;

	pmr_state_s s_r;
	pmr_state_s s_nxt;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Flags sit in bits 7:5, previous mode in 2:0
	function automatic logic [7:0] pd_readback(input logic [2:0] flags, input pmr_mode_e prev);
		return {flags, 2'h0, prev};
	endfunction : pd_readback

	// Pins in the selectable subset are inverted when low polarity is chosen
	function automatic logic [NPIN-1:0] pin_active(input logic [NPIN-1:0] lvl, input logic low);
		return lvl ^ (POL_MASK[NPIN-1:0] & {NPIN{low}});
	endfunction : pin_active

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic             pin_wake;
	logic             any_wake;
	logic             rpin_fall;
	logic             rst_evt;
	logic             wr_fire;
	logic             rd_fire;
	logic [7:0]       rd_byte;
	logic             rd_hit;
	logic [2:0]       cmd;

	always_comb begin
		s_nxt     = s_r;
		pin_wake  = 1'b0;
		any_wake  = 1'b0;
		rpin_fall = 1'b0;
		rst_evt   = 1'b0;
		wr_fire   = 1'b0;
		rd_fire   = 1'b0;
		rd_byte   = 8'h00;
		rd_hit    = 1'b0;
		cmd       = 3'h0;

		// Two-stage synchronisers for asynchronous pins
		s_nxt.pin_s1  = wake_pin;
		s_nxt.pin_s2  = s_r.pin_s1;
		s_nxt.rpin_s1 = reset_pin_n;
		s_nxt.rpin_s2 = s_r.rpin_s1;
		s_nxt.rpin_s3 = s_r.rpin_s2;

		// Write address and data taken independently
		if (axi_req.awvalid && s_r.rsp.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_r.rsp.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.w_data = axi_req.wdata;
			s_nxt.w_strb = axi_req.wstrb;
		end
		if (s_r.rsp.bvalid && axi_req.bready) begin
			s_nxt.rsp.bvalid = 1'b0;
		end

		// Write executes once both halves are held and no response is pending
		wr_fire = s_r.aw_held && s_r.w_held && !s_r.rsp.bvalid;
		if (wr_fire) begin
			s_nxt.aw_held    = 1'b0;
			s_nxt.w_held     = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			s_nxt.rsp.bresp  = RESP_OKAY;
			cmd              = s_r.w_data[2:0];
			unique case (s_r.aw_addr)
				ADDR_POWER_DOWN_COMMAND: begin
					// Writes are ignored during the reset sequence or while asleep
					if (s_r.w_strb[0] && !s_r.sys_reset && s_r.pwr == PWR_RUN
						&& is_sleep_cmd(cmd)) begin
						s_nxt.pwr        = PWR_SLEEP;
						s_nxt.cur_mode   = pmr_mode_e'(cmd);
						s_nxt.wake_flags = FLAGS_NONE;
					end
				end
				ADDR_OPERATING_MODE_CONTROL: begin
					// Upper bits are not stored; software keeps them zero
					if (s_r.w_strb[0] && !s_r.sys_reset) begin
						s_nxt.opm = s_r.w_data[2:0];
					end
				end
				ADDR_RESET_CAUSE: begin
					s_nxt.cause = CAUSE_INTERNAL;
				end
				default: begin
					s_nxt.rsp.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Read channel
		if (s_r.rsp.rvalid && axi_req.rready) begin
			s_nxt.rsp.rvalid = 1'b0;
		end
		rd_fire = axi_req.arvalid && s_r.rsp.arready;
		if (rd_fire) begin
			rd_hit = 1'b1;
			unique case (axi_req.araddr)
				ADDR_POWER_DOWN_COMMAND: begin
					rd_byte          = pd_readback(s_r.wake_flags, s_r.prev_mode);
					s_nxt.wake_flags = FLAGS_NONE;
				end
				ADDR_OPERATING_MODE_CONTROL: begin
					rd_byte = {5'h00, s_r.opm};
				end
				ADDR_RESET_CAUSE: begin
					rd_byte = {5'h00, s_r.cause};
				end
				default: begin
					rd_hit = 1'b0;
				end
			endcase
			s_nxt.rsp.rvalid = 1'b1;
			s_nxt.rsp.rdata  = {24'h000000, rd_byte};
			s_nxt.rsp.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end

		// Wakeup detection; events after a clear still land
		pin_wake = |(pin_active(s_r.pin_s2, s_r.opm[OPM_POL_BIT]) & wake_pin_en);
		any_wake = pin_wake || tick_evt || comp_evt;
		if (s_r.pwr == PWR_SLEEP && any_wake) begin
			// One flag only, pin first, then tick, then comparator
			if (pin_wake) begin
				s_nxt.wake_flags[PD_WAKE_PIN_BIT-5] = 1'b1;
			end else if (tick_evt) begin
				s_nxt.wake_flags[PD_WAKE_TICK_BIT-5] = 1'b1;
			end else begin
				s_nxt.wake_flags[PD_WAKE_COMP_BIT-5] = 1'b1;
			end
			s_nxt.prev_mode = s_r.cur_mode;
			s_nxt.cur_mode  = MODE_RUN;
			s_nxt.pwr       = PWR_RUN;
		end

		// Pin and watchdog resets; cause bits OR in after any clear above
		rpin_fall = s_r.rpin_s3 && !s_r.rpin_s2;
		rst_evt   = rpin_fall || wdt_timeout;
		if (rpin_fall) begin
			s_nxt.cause = s_nxt.cause | CAUSE_PIN;
		end
		if (wdt_timeout) begin
			s_nxt.cause = s_nxt.cause | CAUSE_WDT;
		end
		if (rst_evt) begin
			// Same sequence as the generator reset, cause record excepted
			s_nxt.rst_cnt    = RST_SEQ_CYC[CNT_W-1:0];
			s_nxt.pwr        = PWR_RUN;
			s_nxt.cur_mode   = MODE_RUN;
			s_nxt.prev_mode  = MODE_RUN;
			s_nxt.wake_flags = FLAGS_NONE;
			s_nxt.opm        = OPM_RESET;
		end else if (s_r.rst_cnt != '0) begin
			s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
		end

		// Registered outputs
		s_nxt.sys_reset    = (s_nxt.rst_cnt != '0);
		s_nxt.sleep_active = (s_nxt.pwr == PWR_SLEEP);
		s_nxt.sleep_mode   = s_nxt.cur_mode;
		s_nxt.mcu_clk_stop = (s_nxt.pwr == PWR_SLEEP);
		s_nxt.wdt_halt     = (s_nxt.pwr == PWR_SLEEP) && (s_nxt.cur_mode == MODE_DEEPEST);
		s_nxt.wdt_hold     = (s_nxt.pwr == PWR_SLEEP) && s_nxt.opm[OPM_WDT_BIT]
			&& is_retention(s_nxt.cur_mode);
		s_nxt.latch_lock   = s_nxt.opm[OPM_LOCK_BIT];
		s_nxt.pol_low      = s_nxt.opm[OPM_POL_BIT];

		// Write readies follow the held state, arready the pending read response
		s_nxt.rsp.awready = !s_nxt.aw_held;
		s_nxt.rsp.wready  = !s_nxt.w_held;
		s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

		// Generator reset: everything cleared but rst_cnt and sys_reset, which start the sequence; cause reads 000
		if (!aresetn) begin
			s_nxt           = '0;
			s_nxt.rst_cnt   = RST_SEQ_CYC[CNT_W-1:0];
			s_nxt.sys_reset = 1'b1;
			s_nxt.cause     = CAUSE_INTERNAL;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset is folded into s_nxt so the flop sees one source only
	always_ff @(posedge aclk) begin
		s_r <= s_nxt;
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign axi_rsp        = s_r.rsp;
	assign sys_reset      = s_r.sys_reset;
	assign sleep_active   = s_r.sleep_active;
	assign sleep_mode     = s_r.sleep_mode;
	assign mcu_clk_stop   = s_r.mcu_clk_stop;
	assign wdt_hold_reset = s_r.wdt_hold;
	assign wdt_halt       = s_r.wdt_halt;
	assign ret_latch_lock = s_r.latch_lock;
	assign wake_pol_low   = s_r.pol_low;

endmodule : pmr_top

// ===== verification/pmr_top_asserts.sv
// Checker on the power mode and reset outputs of pmr_top.
// Assumes it is bound into pmr_top and sees only its ports.
module pmr_top_chk
	import pmr_pkg::*;
(
	// Clock, reset and events
	input wire logic      aclk,
	input wire logic      aresetn,
	input wire logic      tick_evt,
	input wire logic      comp_evt,
	input wire logic      wdt_timeout,
	// Watched outputs
	input wire logic      sys_reset,
	input wire logic      sleep_active,
	input wire pmr_mode_e sleep_mode,
	input wire logic      mcu_clk_stop,
	input wire logic      wdt_hold_reset,
	input wire logic      wdt_halt
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_mode; sleep_active == (sleep_mode != MODE_RUN); endproperty
	a_mode: assert property (p_mode) else $error("sleep flag and mode differ");
	property p_rsv; !(sleep_mode inside {MODE_RSV5, MODE_RSV6}); endproperty
	a_rsv: assert property (p_rsv) else $error("reserved mode entered");
	property p_stop; mcu_clk_stop == sleep_active; endproperty
	a_stop: assert property (p_stop) else $error("processor clock stop wrong");
	property p_halt; wdt_halt == (sleep_active && sleep_mode == MODE_DEEPEST); endproperty
	a_halt: assert property (p_halt) else $error("watchdog halt wrong");
	property p_hold;
		wdt_hold_reset |-> sleep_mode inside {MODE_MEMRET_OFF, MODE_MEMRET_ON, MODE_REGRET};
	endproperty
	a_hold: assert property (p_hold) else $error("watchdog held outside retention");
	// Wake must land at the very next edge
	property p_tick; sleep_active && tick_evt |=> !sleep_active; endproperty
	a_tick: assert property (p_tick) else $error("no wake on tick");
	property p_comp; sleep_active && comp_evt |=> !sleep_active; endproperty
	a_comp: assert property (p_comp) else $error("no wake on comparator");
	property p_wdt; wdt_timeout |=> (sys_reset && !sleep_active) [*8]; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset sequence short");
	property p_gen; $rose(aresetn) |-> sys_reset && !sleep_active; endproperty
	a_gen: assert property (p_gen) else $error("generator reset sequence missing");
	c_tick: cover property (sleep_active && tick_evt);
	c_wdt: cover property (wdt_timeout);
	c_hold: cover property (wdt_hold_reset);
endmodule : pmr_top_chk

bind pmr_top pmr_top_chk i_chk (.aclk, .aresetn, .tick_evt, .comp_evt, .wdt_timeout,
	.sys_reset, .sleep_active, .sleep_mode, .mcu_clk_stop, .wdt_hold_reset, .wdt_halt);

// ===== verification/pmr_cpu.sv
// Bus master model of the processor that drives the register bus.
// Assumes one caller at a time; each task waits for the slave's answer.
module pmr_cpu
	import pmr_pkg::*;
(
	// Clock
	input  wire logic         aclk,
	// Register bus
	input  wire pmr_axi_rsp_s rsp,
	output pmr_axi_req_s      req
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req = '0;
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d},
			wstrb: 4'hF, bready: 1'b1, default: '0};
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
		r = rsp.bresp;
	endtask : wr
	// Ready for data at once, held until the data comes
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
		d = rsp.rdata;
		r = rsp.rresp;
	endtask : rd
endmodule : pmr_cpu

// ===== verification/test_power_mode_and_reset_cause.sv
// Self-checking bench of the power mode and reset cause block.
// Assumes the processor model carries all register traffic.
module test_power_mode_and_reset_cause
	import pmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [2:0] code; logic [1:0] src; logic [2:0] opm;} pmr_row_s;
	logic              aclk = 1'b0, aresetn = 1'b0, tick_evt = 1'b0, comp_evt = 1'b0;
	logic              reset_pin_n = 1'b1, wdt_timeout = 1'b0, sl;
	logic [7:0]        wake_pin = 8'h00, wake_pin_en = 8'h00;
	logic              sys_reset, sleep_active, mcu_clk_stop, wdt_hold_reset, wdt_halt;
	logic              ret_latch_lock, wake_pol_low;
	pmr_mode_e         sleep_mode;
	pmr_axi_req_s      axi_req;
	pmr_axi_rsp_s      axi_rsp;
	int                n_errors = 0, check_count = 0, cyc = 0;
	logic [31:0]       d;
	logic [1:0]        r;
	logic [2:0]        prev = 3'h0;
	pmr_row_s          x;
	logic [ADDR_W-1:0] regs [3] = '{ADDR_POWER_DOWN_COMMAND, ADDR_OPERATING_MODE_CONTROL,
		ADDR_RESET_CAUSE};
	// Rows: command, wake source (0 pin, 1 tick, 2 comparator), mode bits
	pmr_row_s rows [8] = '{'{3'h1, 2'h0, 3'h2}, '{3'h2, 2'h1, 3'h1}, '{3'h3, 2'h2, 3'h1},
		'{3'h4, 2'h0, 3'h5}, '{3'h7, 2'h1, 3'h0}, '{3'h5, 2'h2, 3'h0},
		'{3'h6, 2'h1, 3'h0}, '{3'h0, 2'h2, 3'h0}};

	pmr_top i_dut (.aclk, .aresetn, .axi_req, .axi_rsp, .wake_pin, .wake_pin_en, .tick_evt,
		.comp_evt, .reset_pin_n, .wdt_timeout, .sys_reset, .sleep_active, .sleep_mode,
		.mcu_clk_stop, .wdt_hold_reset, .wdt_halt, .ret_latch_lock, .wake_pol_low);
	pmr_cpu i_cpu (.aclk, .rsp(axi_rsp), .req(axi_req));

	// Clock and hang guard, ceiling far above the few hundred cycles needed
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end

	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("errors %0d, checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	// Waits out a whole reset sequence
	task automatic rst_wait();
		while (sys_reset !== 1'b1) @(posedge aclk);
		while (sys_reset !== 1'b0) @(posedge aclk);
	endtask : rst_wait
	task automatic ext_reset(input logic wdt);
		@(posedge aclk);
		if (wdt) wdt_timeout <= 1'b1;
		else reset_pin_n <= 1'b0;
		repeat (3) @(posedge aclk);
		wdt_timeout <= 1'b0;
		reset_pin_n <= 1'b1;
		rst_wait();
	endtask : ext_reset
	// One sleep cycle: mode bits, entry, outputs, wake by the row's source
	task automatic run_row();
		// No low-frequency clock is modelled, so no edge wait is owed
		i_cpu.wr(ADDR_OPERATING_MODE_CONTROL, {5'h00, x.opm}, r);
		@(posedge aclk);
		wake_pin <= {8{x.opm[2]}};
		wake_pin_en <= 8'h04;
		// RC oscillator taken as running before any deep sleep entry
		i_cpu.wr(ADDR_POWER_DOWN_COMMAND, {5'h00, x.code}, r);
		@(posedge aclk);
		#1;
		sl = x.code inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
		chk(sleep_active, sl);
		chk(sleep_mode, sl ? x.code : 3'h0);
		chk(mcu_clk_stop, sl);
		chk(wdt_halt, x.code == 3'h1);
		chk(wdt_hold_reset, x.code inside {3'h2, 3'h3, 3'h4} && x.opm[0]);
		chk(ret_latch_lock, x.opm[1]);
		chk(wake_pol_low, x.opm[2]);
		@(posedge aclk);
		if (x.src == 2'h0) wake_pin[2] <= ~x.opm[2];
		else if (x.src == 2'h1) tick_evt <= 1'b1;
		else comp_evt <= 1'b1;
		@(posedge aclk);
		tick_evt <= 1'b0;
		comp_evt <= 1'b0;
		while (sleep_active !== 1'b0) @(posedge aclk);
		wake_pin[2] <= x.opm[2];
		if (sl) prev = x.code;
	endtask : run_row

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		while (sys_reset !== 1'b0) @(posedge aclk);
		foreach (regs[i]) begin
			i_cpu.rd(regs[i], d, r);
			chk(d, 32'h0);
		end
		i_cpu.rd(12'h000, d, r);
		chk(r, RESP_SLVERR);
		foreach (rows[i]) begin
			x = rows[i];
			run_row();
			i_cpu.rd(ADDR_POWER_DOWN_COMMAND, d, r);
			chk(d, {24'h0, sl && x.src == 2'h0, sl && x.src == 2'h1, sl && x.src == 2'h2,
				2'h0, prev});
			i_cpu.rd(ADDR_POWER_DOWN_COMMAND, d, r);
			chk(d, {29'h0, prev});
			i_cpu.wr(ADDR_POWER_DOWN_COMMAND, 8'h00, r);
		end
		// Unread tick flag must drop on the next entry
		x = '{3'h7, 2'h1, 3'h0};
		run_row();
		x = '{3'h4, 2'h2, 3'h0};
		run_row();
		i_cpu.rd(ADDR_POWER_DOWN_COMMAND, d, r);
		chk(d, 32'h24);
		// Causes pile up, then clear by a write to the cause register
		i_cpu.wr(ADDR_OPERATING_MODE_CONTROL, 8'h02, r);
		ext_reset(1'b0);
		chk(ret_latch_lock, 1'b0);
		i_cpu.rd(ADDR_RESET_CAUSE, d, r);
		chk(d, 32'h1);
		ext_reset(1'b1);
		i_cpu.rd(ADDR_RESET_CAUSE, d, r);
		chk(d, 32'h3);
		i_cpu.wr(ADDR_RESET_CAUSE, 8'h5A, r);
		i_cpu.rd(ADDR_RESET_CAUSE, d, r);
		chk(d, 32'h0);
		// Pin cause again, then a generator reset in mid-run must clear it
		ext_reset(1'b0);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		while (sys_reset !== 1'b0) @(posedge aclk);
		i_cpu.rd(ADDR_RESET_CAUSE, d, r);
		chk(d, 32'h0);
		final_report();
	end
endmodule : test_power_mode_and_reset_cause
